//--- rtl/opsco_map.svh
// Purpose: Register offsets, field positions and reset values of the output port block
// Assumes: AXI4-Lite byte addressing, index times four
// Notes:   Definitions only
`ifndef OPSCO_MAP_SVH
`define OPSCO_MAP_SVH

// --------------------------------------------------------------------------
// Register indices and address width
// --------------------------------------------------------------------------
`define OPSCO_IDX_CLOCK_OUT_CONTROL   16'hFF06
`define OPSCO_IDX_GROUP0_FLOAT        16'hFF30
`define OPSCO_IDX_GROUP0_DATA         16'hFF31
`define OPSCO_IDX_GROUP1_FLOAT        16'hFF32
`define OPSCO_IDX_GROUP1_DATA         16'hFF33
`define OPSCO_IDX_GROUP2_FLOAT        16'hFF34
`define OPSCO_IDX_GROUP2_DATA         16'hFF35
`define OPSCO_IDX_TIMER_CONTROL       16'hFFC1
`define OPSCO_ADDR_W                  18

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define OPSCO_FREQ_SEL_LSB            0
`define OPSCO_FREQ_OUT_EN_BIT         3
`define OPSCO_TIMER_OUT_EN_BIT        2
`define OPSCO_GROUP_FLOAT_BIT         0

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define OPSCO_RST_DATA                4'hF
`define OPSCO_RST_FLOAT               4'h0
`define OPSCO_RST_CLOCK_CTRL          4'h0
`define OPSCO_RST_TIMER_CTRL          4'h0

// --------------------------------------------------------------------------
// Divider ratios of the low-speed clock
// --------------------------------------------------------------------------
`define OPSCO_DIV_SLOW                64
`define OPSCO_DIV_FAST                8

// --------------------------------------------------------------------------
// Bus responses
// --------------------------------------------------------------------------
`define OPSCO_RESP_OKAY               2'h0
`define OPSCO_RESP_SLVERR             2'h2

`endif

//--- rtl/opsco_pkg.sv
// Purpose: Types shared by the output port block
// Assumes: Nothing beyond the map header
// Notes:   Types only
package opsco_pkg;

   typedef enum logic [1:0] {
      OPSCO_FREQ_DIV64 = 2'b00,
      OPSCO_FREQ_DIV8  = 2'b01,
      OPSCO_FREQ_LOW   = 2'b10,
      OPSCO_FREQ_HIGH  = 2'b11
   } opsco_freq_t;

   typedef enum logic [1:0] {
      OPSCO_BUS_IDLE = 2'b00,
      OPSCO_BUS_RESP = 2'b01
   } opsco_bus_t;

endpackage

//--- rtl/opsco_divider.sv
// Purpose: Divides the low-speed oscillator clock by 8 and by 64
// Assumes: low_speed_osc_clock sampled as an ordinary synchronous input
// Notes:   Counts rising edges of the sampled clock level
`timescale 1ns/10ps
`include "opsco_map.svh"

module opsco_divider #(
   parameter int DIV_FAST = `OPSCO_DIV_FAST,
   parameter int DIV_SLOW = `OPSCO_DIV_SLOW
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic low_speed_osc_clock,
   output logic      div_fast_clk,
   output logic      div_slow_clk
);

   localparam int CW = $clog2(DIV_SLOW);

   logic          osc_prev;
   logic [CW-1:0] edge_count;
   logic          osc_rise;

   assign osc_rise = low_speed_osc_clock & ~osc_prev;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= low_speed_osc_clock;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_count <= '0;
      end else if (osc_rise) begin
         edge_count <= edge_count + 1'b1;
      end
   end

   // Top bit of each power-of-two span gives a square wave
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_fast_clk <= 1'b0;
         div_slow_clk <= 1'b0;
      end else begin
         div_fast_clk <= edge_count[$clog2(DIV_FAST)-1];
         div_slow_clk <= edge_count[CW-1];
      end
   end

endmodule

//--- rtl/opsco_pin.sv
// Purpose: One output pin with data, float control and optional clock gating
// Assumes: Float and enable bits come from registers
// Notes:   Clock gating is not aligned to the clock; a short pulse can appear
`timescale 1ns/10ps

module opsco_pin (
   input  wire logic data_bit,
   input  wire logic float_bit,
   input  wire logic special_en,
   input  wire logic special_clk,
   output logic      pin_out,
   output logic      pin_oe
);

   // Data low forces low even with clock selected
   assign pin_out = special_en ? (data_bit & special_clk) : data_bit;
   assign pin_oe  = ~float_bit;

endmodule

//--- rtl/opsco_output_port.sv
// Purpose: Twelve-bit output port with timer and oscillator clock outputs
// Assumes: AXI4-Lite slave, core_clk 50 MHz, low-speed oscillator clock sampled synchronously
// Notes:   Open-drain choice is a build parameter, per pin in group 0 and per group in groups 1 and 2
`timescale 1ns/10ps
`include "opsco_map.svh"

module opsco_output_port #(
   parameter logic [3:0] GROUP0_OPEN_DRAIN = 4'h0,
   parameter logic       GROUP1_OPEN_DRAIN = 1'b0,
   parameter logic       GROUP2_OPEN_DRAIN = 1'b0
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic [`OPSCO_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`OPSCO_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     timer_clock_out,
   input  wire logic                     low_speed_osc_clock,
   input  wire logic                     high_speed_osc_clock,
   output logic [11:0]                   port_out,
   output logic [11:0]                   port_oe
);

   // -----------------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------------
   logic [3:0]          group0_output_data;
   logic [3:0]          group1_output_data;
   logic [3:0]          group2_output_data;
   logic [3:0]          group0_float_control;
   logic                group1_float_bit;
   logic                group2_float_bit;
   logic                freq_out_enable;
   opsco_pkg::opsco_freq_t freq_select;
   logic                timer_out_enable;

   // -----------------------------------------------------------------------
   // Register select codes; zero means no register
   // -----------------------------------------------------------------------
   localparam logic [3:0] SEL_NONE       = 4'h0;
   localparam logic [3:0] SEL_CLOCK_CTRL = 4'h1;
   localparam logic [3:0] SEL_G0_FLOAT   = 4'h2;
   localparam logic [3:0] SEL_G0_DATA    = 4'h3;
   localparam logic [3:0] SEL_G1_FLOAT   = 4'h4;
   localparam logic [3:0] SEL_G1_DATA    = 4'h5;
   localparam logic [3:0] SEL_G2_FLOAT   = 4'h6;
   localparam logic [3:0] SEL_G2_DATA    = 4'h7;
   localparam logic [3:0] SEL_TIMER_CTRL = 4'h8;

   // -----------------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------------
   function automatic logic [3:0] opsco_decode(input logic [`OPSCO_ADDR_W-1:0] addr);
      logic [15:0] idx;
      idx = addr[`OPSCO_ADDR_W-1:2];
      if (addr[1:0] != 2'h0) begin
         opsco_decode = SEL_NONE;
      end else begin
         unique case (idx)
            `OPSCO_IDX_CLOCK_OUT_CONTROL: opsco_decode = SEL_CLOCK_CTRL;
            `OPSCO_IDX_GROUP0_FLOAT:      opsco_decode = SEL_G0_FLOAT;
            `OPSCO_IDX_GROUP0_DATA:       opsco_decode = SEL_G0_DATA;
            `OPSCO_IDX_GROUP1_FLOAT:      opsco_decode = SEL_G1_FLOAT;
            `OPSCO_IDX_GROUP1_DATA:       opsco_decode = SEL_G1_DATA;
            `OPSCO_IDX_GROUP2_FLOAT:      opsco_decode = SEL_G2_FLOAT;
            `OPSCO_IDX_GROUP2_DATA:       opsco_decode = SEL_G2_DATA;
            `OPSCO_IDX_TIMER_CONTROL:     opsco_decode = SEL_TIMER_CTRL;
            default:                      opsco_decode = SEL_NONE;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------------
   // Write channel
   // -----------------------------------------------------------------------
   logic                     aw_held;
   logic                     w_held;
   logic [`OPSCO_ADDR_W-1:0] aw_addr;
   logic [31:0]              w_data;
   logic                     w_lane0;
   logic                     wr_fire;
   logic [3:0]               wr_sel;
   logic [3:0]               wd;

   // Address and data come in either order; each waits here for the other
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
   assign wr_sel        = opsco_decode(aw_addr);
   assign wd            = w_data[3:0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         w_data  <= s_axi_wdata;
         w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `OPSCO_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == SEL_NONE) ? `OPSCO_RESP_SLVERR : `OPSCO_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Register writes, effective at the next edge
   // -----------------------------------------------------------------------
   logic wr_en;
   assign wr_en = wr_fire & w_lane0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group0_output_data <= `OPSCO_RST_DATA;
      end else if (wr_en && wr_sel == SEL_G0_DATA) begin
         group0_output_data <= wd;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group1_output_data <= `OPSCO_RST_DATA;
      end else if (wr_en && wr_sel == SEL_G1_DATA) begin
         group1_output_data <= wd;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group2_output_data <= `OPSCO_RST_DATA;
      end else if (wr_en && wr_sel == SEL_G2_DATA) begin
         group2_output_data <= wd;
      end
   end

   // -----------------------------------------------------------------------
   // Float controls
   // -----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group0_float_control <= `OPSCO_RST_FLOAT;
      end else if (wr_en && wr_sel == SEL_G0_FLOAT) begin
         group0_float_control <= wd;
      end
   end

   // Shared groups keep only one bit; the rest reads back 0
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group1_float_bit <= 1'b0;
      end else if (wr_en && wr_sel == SEL_G1_FLOAT) begin
         group1_float_bit <= wd[`OPSCO_GROUP_FLOAT_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         group2_float_bit <= 1'b0;
      end else if (wr_en && wr_sel == SEL_G2_FLOAT) begin
         group2_float_bit <= wd[`OPSCO_GROUP_FLOAT_BIT];
      end
   end

   // -----------------------------------------------------------------------
   // Special output controls
   // -----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_out_enable <= 1'b0;
         freq_select     <= opsco_pkg::OPSCO_FREQ_DIV64;
      end else if (wr_en && wr_sel == SEL_CLOCK_CTRL) begin
         freq_out_enable <= wd[`OPSCO_FREQ_OUT_EN_BIT];
         freq_select     <= opsco_pkg::opsco_freq_t'(wd[`OPSCO_FREQ_SEL_LSB +: 2]);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_out_enable <= 1'b0;
      end else if (wr_en && wr_sel == SEL_TIMER_CTRL) begin
         timer_out_enable <= wd[`OPSCO_TIMER_OUT_EN_BIT];
      end
   end

   // -----------------------------------------------------------------------
   // Read channel
   // -----------------------------------------------------------------------
   logic [3:0] rd_sel;
   logic [3:0] rd_val;

   // Answer is registered; a new address waits while one stands
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_sel        = opsco_decode(s_axi_araddr);

   always_comb begin
      unique case (rd_sel)
         SEL_CLOCK_CTRL: rd_val = {freq_out_enable, 1'b0, freq_select};
         SEL_G0_FLOAT:   rd_val = group0_float_control;
         SEL_G0_DATA:    rd_val = group0_output_data;
         SEL_G1_FLOAT:   rd_val = {3'h0, group1_float_bit};
         SEL_G1_DATA:    rd_val = group1_output_data;
         SEL_G2_FLOAT:   rd_val = {3'h0, group2_float_bit};
         SEL_G2_DATA:    rd_val = group2_output_data;
         SEL_TIMER_CTRL: rd_val = {1'b0, timer_out_enable, 2'h0};
         default:        rd_val = 4'h0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `OPSCO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {28'h0000000, rd_val};
         s_axi_rresp  <= (rd_sel == SEL_NONE) ? `OPSCO_RESP_SLVERR : `OPSCO_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Clock sources for the special outputs
   // -----------------------------------------------------------------------
   logic div8_clk;
   logic div64_clk;
   logic oscillator_clock_out;

   // Low clock is sampled, so it must stay well below core_clk
   opsco_divider u_divider (
      .core_clk            (core_clk),
      .rst_n               (rst_n),
      .low_speed_osc_clock (low_speed_osc_clock),
      .div_fast_clk        (div8_clk),
      .div_slow_clk        (div64_clk)
   );

   // High oscillator must already be running when picked
   always_comb begin
      unique case (freq_select)
         opsco_pkg::OPSCO_FREQ_HIGH:  oscillator_clock_out = high_speed_osc_clock;
         opsco_pkg::OPSCO_FREQ_LOW:   oscillator_clock_out = low_speed_osc_clock;
         opsco_pkg::OPSCO_FREQ_DIV8:  oscillator_clock_out = div8_clk;
         opsco_pkg::OPSCO_FREQ_DIV64: oscillator_clock_out = div64_clk;
      endcase
   end

   // -----------------------------------------------------------------------
   // Pins
   // -----------------------------------------------------------------------
   logic [11:0] data_all;
   logic [11:0] float_all;
   logic [11:0] special_en;
   logic [11:0] special_clk;
   logic [11:0] drive_val;
   logic [11:0] drive_en;
   logic [11:0] open_drain;

   assign data_all    = {group2_output_data, group1_output_data, group0_output_data};
   // Float wins over data and over a selected clock
   assign float_all   = {{4{group2_float_bit}}, {4{group1_float_bit}}, group0_float_control};
   assign special_en  = {8'h00, freq_out_enable, timer_out_enable, 2'h0};
   assign special_clk = {8'h00, oscillator_clock_out, timer_clock_out, 2'h0};
   assign open_drain  = {{4{GROUP2_OPEN_DRAIN}}, {4{GROUP1_OPEN_DRAIN}}, GROUP0_OPEN_DRAIN};

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_pin
         opsco_pin u_pin (
            .data_bit    (data_all[gi]),
            .float_bit   (float_all[gi]),
            .special_en  (special_en[gi]),
            .special_clk (special_clk[gi]),
            .pin_out     (drive_val[gi]),
            .pin_oe      (drive_en[gi])
         );
         // Open-drain only pulls low; high is left to the outside
         assign port_out[gi] = drive_val[gi];
         assign port_oe[gi]  = drive_en[gi] & ~(open_drain[gi] & drive_val[gi]);
      end
   endgenerate

endmodule

//--- tb/opsco_output_port_sva.sv
// Purpose: Port-level assertions for the output port block
// Assumes: Push-pull build; address and data are offered together
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`include "opsco_map.svh"

module opsco_output_port_sva (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic [11:0] port_out,
   input wire logic [11:0] port_oe
);
   // ----------------
   // Write sequences
   // ----------------
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence wr_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_to_s(logic [15:0] idx);
      wr_s ##0 (s_axi_wstrb[0] && s_axi_awaddr[17:2] == idx);
   endsequence
   // ----------------
   // Checks
   // ----------------
   reset_high_a: assert property (
      $rose(rst_n) |-> port_out == 12'hFFF && port_oe == 12'hFFF) else $error("Pins not high");
   g0_data_a: assert property (wr_to_s(`OPSCO_IDX_GROUP0_DATA) |=>
      ##1 s_axi_bvalid && port_out[1:0] == $past(s_axi_wdata[1:0], 2))
      else $error("Data not on pins");
   g0_float_a: assert property (wr_to_s(`OPSCO_IDX_GROUP0_FLOAT) |=>
      ##1 port_oe[3:0] == ~$past(s_axi_wdata[3:0], 2)) else $error("Pin float wrong");
   g1_float_a: assert property (wr_to_s(`OPSCO_IDX_GROUP1_FLOAT) |=>
      ##1 port_oe[7:4] == {4{~$past(s_axi_wdata[0], 2)}}) else $error("Group float wrong");
   g2_data_a: assert property (wr_to_s(`OPSCO_IDX_GROUP2_DATA) |=>
      ##1 port_out[11:8] == $past(s_axi_wdata[3:0], 2)) else $error("Group data wrong");
   unmapped_err_a: assert property (wr_s ##0 s_axi_awaddr[17:2] < 16'hFF06 |=>
      ##1 s_axi_bvalid && s_axi_bresp == `OPSCO_RESP_SLVERR) else $error("No error response");
   strobe_off_a: assert property (wr_s ##0 !s_axi_wstrb[0] |=>
      ##1 $stable(port_out[1:0]) && $stable(port_oe[3:0])) else $error("Masked write landed");
   read_pad_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:4] == 28'h0) else $error("Read answer wrong");
   write_hold_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("Write taken during response");
endmodule

bind opsco_output_port opsco_output_port_sva u_sva (
   .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .port_out(port_out), .port_oe(port_oe)
);

//--- tb/opsco_far_side.sv
// Purpose: Far side of the output port: clock sources and pin wires
// Assumes: Oscillators and timer run free from time zero
// Notes:   No pull on the pins, so a floated pin reads z
`timescale 1ns/10ps

module opsco_far_side (
   input  wire logic [11:0] port_out,
   input  wire logic [11:0] port_oe,
   output logic             timer_clock_out,
   output logic             low_speed_osc_clock,
   output logic             high_speed_osc_clock,
   output wire logic [11:0] pins
);
   initial begin
      timer_clock_out = 1'b0;
      low_speed_osc_clock = 1'b0;
      high_speed_osc_clock = 1'b0;
   end
   always #50 timer_clock_out = ~timer_clock_out;
   always #80 low_speed_osc_clock = ~low_speed_osc_clock;
   // Running from power-up, long before it is selected
   always #15 high_speed_osc_clock = ~high_speed_osc_clock;
   for (genvar i = 0; i < 12; i++) begin : g_pin
      assign pins[i] = port_oe[i] ? port_out[i] : 1'bz;
   end
endmodule

//--- tb/opsco_output_port_bench.sv
// Purpose: Self-checking bench of the output port block
// Assumes: Register bus answers are queued and checked by a monitor
// Notes:   Clock rates are counted over a fixed window
`timescale 1ns/10ps
`include "opsco_map.svh"

module opsco_output_port_bench;
   localparam int WIN = 1280;
   localparam real PER [4] = '{10240.0, 1280.0, 160.0, 30.0};
   localparam logic [15:0] IDX [6] = '{`OPSCO_IDX_GROUP0_FLOAT, `OPSCO_IDX_GROUP0_DATA,
      `OPSCO_IDX_GROUP1_FLOAT, `OPSCO_IDX_GROUP1_DATA, `OPSCO_IDX_GROUP2_FLOAT,
      `OPSCO_IDX_GROUP2_DATA};
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, tmr, losc, hosc;
   logic [17:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [31:0] v [6];
   logic [3:0]  ws, d0, d1, d2, f0;
   logic [1:0]  bresp, rresp;
   logic        f1, f2;
   logic [11:0] pout, poe;
   wire logic [11:0] pins;
   logic [33:0] exp_b [$];
   logic [33:0] exp_r [$];
   int          fails = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n2, n3, nt;

   opsco_output_port u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .timer_clock_out(tmr),
      .low_speed_osc_clock(losc), .high_speed_osc_clock(hosc), .port_out(pout), .port_oe(poe)
   );
   opsco_far_side u_far (
      .port_out(pout), .port_oe(poe), .timer_clock_out(tmr), .low_speed_osc_clock(losc),
      .high_speed_osc_clock(hosc), .pins(pins)
   );

   // ----------------
   // Checking
   // ----------------
   always #10 core_clk = ~core_clk;
   always @(posedge pins[2]) n2++;
   always @(posedge pins[3]) n3++;
   always @(posedge tmr) nt++;

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (bv && br) check({32'h0, bresp}, exp_b.pop_front());
      if (rv && rr) check({rresp, rdat}, exp_r.pop_front());
      if (cyc == 20000) begin
         fails++;
         end_of_test;
      end
   end

   // ----------------
   // Bus master
   // ----------------
   function automatic logic mapped(input logic [15:0] idx);
      return idx inside {`OPSCO_IDX_CLOCK_OUT_CONTROL, `OPSCO_IDX_TIMER_CONTROL, IDX[0], IDX[1],
         IDX[2], IDX[3], IDX[4], IDX[5]};
   endfunction

   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
      @(posedge core_clk);
      exp_b.push_back({32'h0, mapped(idx) ? `OPSCO_RESP_OKAY : `OPSCO_RESP_SLVERR});
      awa <= {idx, 2'b00};
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wr_rdy));
      do @(posedge core_clk); while (!bv);
      br <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx, input logic [3:0] e);
      @(posedge core_clk);
      exp_r.push_back({mapped(idx) ? `OPSCO_RESP_OKAY : `OPSCO_RESP_SLVERR, 28'h0, e});
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge core_clk); while (!arr);
      arv <= 1'b0;
      do @(posedge core_clk); while (!rv);
      rr <= 1'b0;
   endtask

   task automatic pin_check;
      logic [11:0] e;
      e = {d2, d1, d0};
      for (int i = 0; i < 12; i++) if (i < 4 ? f0[i] : (i < 8 ? f1 : f2)) e[i] = 1'bz;
      check({22'h0, pins}, {22'h0, e});
   endtask

   task automatic measure;
      n2 = 0;
      n3 = 0;
      nt = 0;
      repeat (WIN) @(posedge core_clk);
   endtask

   // ----------------
   // Scenarios
   // ----------------
   initial begin
      {awv, wv, br, arv, rr} = 5'h0;
      awa = 18'h0;
      ara = 18'h0;
      wd = 32'h0;
      ws = 4'h0;
      {d0, d1, d2, f0, f1, f2} = {12'hFFF, 4'h0, 2'b00};
      void'($urandom(38041));
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      pin_check;
      rd(`OPSCO_IDX_CLOCK_OUT_CONTROL, 4'h0);
      rd(`OPSCO_IDX_TIMER_CONTROL, 4'h0);
      for (int i = 0; i < 6; i++) rd(IDX[i], i[0] ? 4'hF : 4'h0);
      repeat (4) begin
         for (int i = 0; i < 6; i++) begin
            v[i] = $urandom;
            wr(IDX[i], v[i], 4'hF);
         end
         {f0, d0, f1, d1, f2, d2} = {v[0][3:0], v[1][3:0], v[2][0], v[3][3:0], v[4][0], v[5][3:0]};
         pin_check;
         for (int i = 0; i < 6; i++) rd(IDX[i], i inside {2, 4} ? {3'h0, v[i][0]} : v[i][3:0]);
      end
      wr(16'h0000, 32'hF, 4'hF);
      rd(16'h0001, 4'h0);
      wr(IDX[1], {28'h0, ~d0}, 4'h0);
      pin_check;
      {f0, d0} = 8'h0F;
      wr(IDX[0], 32'h0, 4'hF);
      wr(IDX[1], 32'hF, 4'hF);
      wr(`OPSCO_IDX_TIMER_CONTROL, 32'h4, 4'hF);
      measure;
      check({33'h0, n2 > nt - 2 && n2 < nt + 2}, 34'h1);
      for (int s = 0; s < 4; s++) begin
         wr(`OPSCO_IDX_CLOCK_OUT_CONTROL, 32'hC | s, 4'hF);
         rd(`OPSCO_IDX_CLOCK_OUT_CONTROL, 4'h8 | s[3:0]);
         measure;
         check({33'h0, n3 > WIN * 20.0 / PER[s] - 1.5 && n3 < WIN * 20.0 / PER[s] + 1.5}, 34'h1);
      end
      d0 = 4'h3;
      wr(IDX[1], {28'h0, d0}, 4'hF);
      pin_check;
      f0 = 4'hC;
      wr(IDX[0], {28'h0, f0}, 4'hF);
      pin_check;
      {f0, d0} = 8'h0F;
      wr(IDX[0], 32'h0, 4'hF);
      wr(IDX[1], 32'hF, 4'hF);
      wr(`OPSCO_IDX_TIMER_CONTROL, 32'h0, 4'hF);
      wr(`OPSCO_IDX_CLOCK_OUT_CONTROL, 32'h3, 4'hF);
      measure;
      check({2'h0, n2[15:0], n3[15:0]}, 34'h0);
      pin_check;
      end_of_test;
   end
endmodule
